// ==== src/instr_decode_pkg.sv ====
// constants and carrier types for the serial instruction decoder
// assumes a single 50 MHz clock domain and an active-low async reset
package instr_decode_pkg;

    localparam int unsigned BYTE_BITS = 8;
    localparam logic [2:0]  BIT_LAST  = 3'h7;

    // transfer direction held in the top command bit
    localparam logic DIR_READ  = 1'b0;
    localparam logic DIR_WRITE = 1'b1;

    // internal register codes in the register select field
    localparam logic [1:0] REG_RESULT    = 2'h0;
    localparam logic [1:0] REG_CONFIG    = 2'h1;
    localparam logic [1:0] REG_OFFSET    = 2'h2;
    localparam logic [1:0] REG_FULLSCALE = 2'h3;

    // byte index with no register byte behind it
    localparam logic [1:0] BYTE_NONE = 2'h3;
    localparam logic [1:0] BYTE_STEP = 2'h1;
    localparam logic [1:0] COUNT_ONE = 2'h0;

    // reads of unmapped bytes return this filler
    localparam logic [7:0] READ_FILL = 8'h00;

    // byte order steering level
    localparam logic ORDER_DESCEND = 1'b0;

    typedef enum logic {
        ST_COMMAND = 1'b0,
        ST_DATA    = 1'b1
    } phase_e;

    // command byte as shifted in, top bit first
    typedef struct packed {
        logic       write;
        logic       byte_count_high;
        logic       byte_count_low;
        logic       fullscale_polarity_select;
        logic       register_select_high;
        logic       register_select_low;
        logic       start_byte_high;
        logic       start_byte_low;
    } cmd_s;

    // internal register byte address presented to the register file
    typedef struct packed {
        logic       fullscale_polarity_select;
        logic [1:0] register_select;
        logic [1:0] byte_index;
    } addr_s;

endpackage

// ==== src/byte_shifter.sv ====
// serial to parallel shifter: collects eight strobed bits, top bit first
// assumes bit_valid_i is a one-cycle strobe synchronous to clk_i
`timescale 1ns/1ns
module byte_shifter (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // serial input
    input  wire logic       bit_valid_i,
    input  wire logic       bit_i,
    // assembled byte
    output logic [7:0]      byte_o,
    output logic            done_o
);
    logic [7:0] byte_q;
    logic [2:0] cnt_q;
    logic       done_q;
    wire        last_bit = bit_valid_i && (cnt_q == instr_decode_pkg::BIT_LAST);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            byte_q <= 8'h00;
            cnt_q  <= 3'h0;
            done_q <= 1'b0;
        end else begin
            done_q <= last_bit;
            if (bit_valid_i) begin
                byte_q <= {byte_q[6:0], bit_i};
                cnt_q  <= cnt_q + 3'h1;
            end
        end
    end

    assign byte_o = byte_q;
    assign done_o = done_q;

endmodule

// ==== src/serial_instruction_decoder.sv ====
// serial instruction decoder: takes the command byte of every
// communication cycle and steers the data phase that follows it
// assumes bits arrive as synchronous strobes at least four cycles apart
`timescale 1ns/1ns

// How it works
// [RL1] eight-bit command byte opens each cycle
// [RL2] top bit: zero read, one write
// [RL3] bits six, five give one to four bytes
// [RL4] bit four picks positive or negative fullscale
// [RL5] bits three, two register; one, zero start byte
// [RL6] codes 0000-0010 select result bytes zero-two
// [RL7] codes 0100, 0101 select configuration bytes zero, one
// [RL8] 0110 config two; 10xx offset; 11xx fullscale
// [RL9] command phase, data phase, then wait again
// [RL10] byte order descends or ascends by direction bit
// [RL11] unassigned byte codes perform no register access
module serial_instruction_decoder (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    nrst_i,
    // serial port, bit level
    input  wire logic                    bit_valid_i,
    input  wire logic                    bit_i,
    output logic                         sdo_o,
    output logic                         sdo_oe_o,
    // configuration level from the configuration register
    input  wire logic                    byte_direction_i,
    // register file access
    output instr_decode_pkg::addr_s      addr_o,
    output logic                         addr_valid_o,
    output logic                         wr_stb_o,
    output logic [7:0]                   wr_data_o,
    input  wire logic [7:0]              rd_byte_i,
    // phase status
    output logic                         data_phase_o,
    output logic                         write_o
);
    instr_decode_pkg::phase_e state_q;
    instr_decode_pkg::addr_s  addr_q;
    logic       dir_q;
    logic [1:0] left_q;
    logic       load_q;
    logic [7:0] tx_q;
    logic       wr_stb_q;
    logic [7:0] wr_data_q;

    logic [7:0] rx_byte;
    logic       rx_done;

    byte_shifter u_shift (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .bit_valid_i (bit_valid_i),
        .bit_i       (bit_i),
        .byte_o      (rx_byte),
        .done_o      (rx_done)
    );

    // decode of the freshly received byte as a command
    instr_decode_pkg::cmd_s cmd_w;
    assign cmd_w = instr_decode_pkg::cmd_s'(rx_byte);

    wire in_cmd   = (state_q == instr_decode_pkg::ST_COMMAND);
    wire in_data  = (state_q == instr_decode_pkg::ST_DATA);
    wire cmd_done = in_cmd && rx_done; // RL1
    wire dat_done = in_data && rx_done;
    wire last_byte = (left_q == instr_decode_pkg::COUNT_ONE);
    wire is_write = (dir_q == instr_decode_pkg::DIR_WRITE); // RL2
    wire mapped   = (addr_q.byte_index != instr_decode_pkg::BYTE_NONE); // RL11

    // command fields to register byte address
    wire [1:0] cmd_count = {cmd_w.byte_count_high,
                            cmd_w.byte_count_low}; // RL3
    wire [1:0] cmd_reg   = {cmd_w.register_select_high,
                            cmd_w.register_select_low}; // RL5
    wire [1:0] cmd_start = {cmd_w.start_byte_high,
                            cmd_w.start_byte_low}; // RL5
    instr_decode_pkg::addr_s cmd_addr;
    assign cmd_addr = '{fullscale_polarity_select:
                            cmd_w.fullscale_polarity_select, // RL4
                        register_select: cmd_reg, // RL6 RL7 RL8
                        byte_index: cmd_start};

    // next byte index in a multi-byte transfer
    wire descend = (byte_direction_i == instr_decode_pkg::ORDER_DESCEND);
    wire [1:0] idx_down = addr_q.byte_index - instr_decode_pkg::BYTE_STEP;
    wire [1:0] idx_up   = addr_q.byte_index + instr_decode_pkg::BYTE_STEP;
    wire [1:0] idx_next = descend ? idx_down : idx_up; // RL10

    wire more_bytes = dat_done && !last_byte;
    wire wr_take    = dat_done && is_write && mapped; // RL11
    wire load_next  = (cmd_done && !cmd_w.write)
                      || (more_bytes && !is_write);

    // phase sequencing
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= instr_decode_pkg::ST_COMMAND;
        end else begin
            case (state_q)
                instr_decode_pkg::ST_COMMAND: begin
                    if (rx_done) begin
                        state_q <= instr_decode_pkg::ST_DATA; // RL9
                    end
                end
                instr_decode_pkg::ST_DATA: begin
                    if (rx_done && last_byte) begin
                        state_q <= instr_decode_pkg::ST_COMMAND; // RL9
                    end
                end
                default: state_q <= instr_decode_pkg::ST_COMMAND;
            endcase
        end
    end

    // command capture and byte stepping
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_q <= '0;
            dir_q  <= instr_decode_pkg::DIR_READ;
            left_q <= instr_decode_pkg::COUNT_ONE;
        end else if (cmd_done) begin
            addr_q <= cmd_addr; // RL1
            dir_q  <= cmd_w.write; // RL2
            left_q <= cmd_count; // RL3
        end else if (more_bytes) begin
            addr_q.byte_index <= idx_next; // RL10
            left_q <= left_q - instr_decode_pkg::BYTE_STEP;
        end
    end

    // write data towards the register file
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_stb_q  <= 1'b0;
            wr_data_q <= 8'h00;
        end else begin
            wr_stb_q <= wr_take;
            if (wr_take) begin
                wr_data_q <= rx_byte;
            end
        end
    end

    // read data: load a byte at each read byte start, shift per bit
    wire [7:0] rd_fill = mapped ? rd_byte_i : instr_decode_pkg::READ_FILL;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            load_q <= 1'b0;
            tx_q   <= 8'h00;
        end else begin
            load_q <= load_next;
            if (load_q) begin
                tx_q <= rd_fill; // RL11
            end else if (bit_valid_i && in_data && !is_write) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    assign sdo_o        = tx_q[7];
    assign sdo_oe_o     = in_data && !is_write;
    assign addr_o       = addr_q;
    assign addr_valid_o = in_data && mapped;
    assign wr_stb_o     = wr_stb_q;
    assign wr_data_o    = wr_data_q;
    assign data_phase_o = in_data;
    assign write_o      = dir_q;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    chk_cmd_enters_data: assert property ( // RL1
        cmd_done |=> in_data [*1] ##0 (addr_o == $past(cmd_addr)))
        else $error("command byte did not open the data phase");
    chk_dir_capture: assert property ( // RL2
        cmd_done |=> (write_o == $past(cmd_w.write)) && (sdo_oe_o != write_o))
        else $error("direction not taken from top bit");
    chk_count_capture: assert property ( // RL3
        cmd_done |=> (left_q == $past(cmd_count)))
        else $error("byte count not taken from count bits");
    chk_fsc_capture: assert property ( // RL4
        cmd_done |=> (addr_o.fullscale_polarity_select
                      == $past(cmd_w.fullscale_polarity_select)))
        else $error("fullscale select not captured");
    chk_start_capture: assert property ( // RL5
        cmd_done |=> (addr_o.byte_index == $past(cmd_start))
                     && (addr_o.register_select == $past(cmd_reg)))
        else $error("register or start byte not captured");
    chk_result_byte: assert property ( // RL6
        cmd_done && (rx_byte[3:0] == 4'h2) |=>
            (addr_o.register_select == instr_decode_pkg::REG_RESULT)
            && (addr_o.byte_index == 2'h2) && addr_valid_o)
        else $error("result byte two not selected");
    chk_config_byte: assert property ( // RL7
        cmd_done && (rx_byte[3:0] == 4'h5) |=>
            (addr_o.register_select == instr_decode_pkg::REG_CONFIG)
            && (addr_o.byte_index == 2'h1))
        else $error("configuration byte one not selected");
    chk_fullscale_byte: assert property ( // RL8
        cmd_done && (rx_byte[3:0] == 4'hE) |=>
            (addr_o.register_select == instr_decode_pkg::REG_FULLSCALE)
            && (addr_o.byte_index == 2'h2))
        else $error("fullscale byte two not selected");
    chk_phase_end: assert property ( // RL9
        dat_done && last_byte |=> in_cmd && !sdo_oe_o)
        else $error("data phase did not end after last byte");
    chk_byte_order: assert property ( // RL10
        more_bytes |=> (addr_o.byte_index == ($past(byte_direction_i)
            ? $past(addr_q.byte_index) + 2'h1
            : $past(addr_q.byte_index) - 2'h1)))
        else $error("byte index stepped the wrong way");
    chk_unmapped_write: assert property ( // RL11
        dat_done && !mapped |=> !wr_stb_o)
        else $error("write to unassigned byte reached register file");

    cov_write_multi: cover property (
        cmd_done && cmd_w.write && (cmd_count != 2'h0));
    cov_read_cycle: cover property (dat_done && !is_write && last_byte);
    cov_ascending: cover property (more_bytes && !descend);

endmodule

// ==== tb/regfile_model.sv ====
// register file model behind the decoder: 32 bytes indexed by address
// assumes a write strobe pairs with the address of the cycle before
`timescale 1ns/1ns
module regfile_model (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    nrst_i,
    // decoder side
    input  wire instr_decode_pkg::addr_s addr_i,
    input  wire logic                    addr_valid_i,
    input  wire logic                    wr_stb_i,
    input  wire logic [7:0]              wr_data_i,
    output logic [7:0]                   rd_byte_o
);
    logic [7:0]              mem [32];
    logic [7:0]              last_q;
    instr_decode_pkg::addr_s prev_q;
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i] = 8'h30 + 8'(i);
        end
    end
    // an unselected byte shows the inverse of the rd_byte_o value of the cycle before
    assign rd_byte_o = addr_valid_i ? mem[addr_i] : ~last_q;
    // plain always: mem is also preloaded by the initial block above
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev_q <= '0;
            last_q <= 8'h00;
        end else begin
            prev_q <= addr_i;
            last_q <= rd_byte_o;
            if (wr_stb_i) begin
                mem[prev_q] <= wr_data_i;
            end
        end
    end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench: host side drives bit strobes, a register model
// answers reads; assumes strobes four cycles apart, top bit first
`timescale 1ns/1ns
module testbench;
    logic                    clk_i = 1'b0;
    logic                    nrst_i = 1'b0;
    logic                    bit_valid_i = 1'b0;
    logic                    bit_i = 1'b0;
    logic                    bd = 1'b0;
    logic                    sdo_o, sdo_oe_o, addr_valid_o, wr_stb_o;
    logic                    data_phase_o, write_o;
    logic [7:0]              wr_data_o, rd_byte_i, seq, lastw;
    logic [7:0]              exp_mem [32];
    instr_decode_pkg::addr_s addr_o;
    int                      err_total = 0;
    int                      num_checks = 0;
    int                      wr_seen = 0;
    int                      wr_exp = 0;
    logic [8:0]              ops [14] = '{9'h084, 9'h0CA, 9'h1F4, 9'h0BC,
        9'h19E, 9'h002, 9'h04A, 9'h174, 9'h01C, 9'h05E, 9'h00D, 9'h16F,
        9'h0A5, 9'h004};

    always #10 clk_i = ~clk_i;

    // count write strobes away from the edge that launches them
    always @(negedge clk_i) begin
        if (wr_stb_o === 1'b1) begin
            wr_seen++;
        end
    end

    serial_instruction_decoder i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
        .bit_valid_i(bit_valid_i), .bit_i(bit_i), .sdo_o(sdo_o),
        .sdo_oe_o(sdo_oe_o), .byte_direction_i(bd), .addr_o(addr_o),
        .addr_valid_o(addr_valid_o), .wr_stb_o(wr_stb_o),
        .wr_data_o(wr_data_o), .rd_byte_i(rd_byte_i),
        .data_phase_o(data_phase_o), .write_o(write_o));
    regfile_model i_rf (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_o),
        .addr_valid_i(addr_valid_o), .wr_stb_i(wr_stb_o),
        .wr_data_i(wr_data_o), .rd_byte_o(rd_byte_i));

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // eight strobes top bit first, sdo_o sampled before each strobe
    task automatic send_byte(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk_i);
            r[i] = sdo_o;
            bit_valid_i = 1'b1;
            bit_i = b[i];
            @(negedge clk_i);
            bit_valid_i = 1'b0;
            repeat (2) @(negedge clk_i);
        end
        @(negedge clk_i);
    endtask

    // one communication cycle: command byte, then its data bytes
    task automatic xfer(input logic [8:0] op);
        logic [7:0] c, r;
        logic [1:0] idx;
        logic [4:0] a;
        c = op[7:0];
        bd = op[8];
        idx = c[1:0];
        send_byte(c, r);
        chk("phase", 8'(data_phase_o), 8'h01);
        chk("dir", 8'(write_o), 8'(c[7]));
        chk("oe", 8'(sdo_oe_o), 8'(!c[7]));
        chk("addr", 8'(addr_o), 8'(c[4:0]));
        chk("valid", 8'(addr_valid_o), 8'(idx != 2'h3));
        for (int k = 0; k <= int'(c[6:5]); k++) begin
            a = {c[4:2], idx};
            send_byte(seq, r);
            if (c[7]) begin
                if (idx != 2'h3) begin
                    exp_mem[a] = seq;
                    lastw = seq;
                    wr_exp++;
                end
                chk("wdata", wr_data_o, lastw);
            end else begin
                chk("rdata", r, (idx == 2'h3) ? 8'h00 : exp_mem[a]);
            end
            idx = bd ? idx + 2'h1 : idx - 2'h1;
            if (c[7] && k < int'(c[6:5])) begin
                chk("step", 8'(addr_o), 8'({c[4:2], idx}));
            end
            seq = seq + 8'h0B;
        end
        chk("idle", 8'({data_phase_o, sdo_oe_o}), 8'h00);
    endtask

    initial begin
        seq = 8'hC1;
        lastw = 8'h00;
        for (int i = 0; i < 32; i++) begin
            exp_mem[i] = 8'h30 + 8'(i);
        end
        repeat (16) @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        chk("rst", 8'({data_phase_o, sdo_oe_o, wr_stb_o}), 8'h00);
        foreach (ops[n]) begin
            xfer(ops[n]);
        end
        for (int i = 0; i < 32; i++) begin
            chk("mem", i_rf.mem[i], exp_mem[i]);
        end
        chk("wstb", 8'(wr_seen), 8'(wr_exp));
        give_verdict();
    end
endmodule
